// ==== charge_cfg_pkg.sv ====
// Offsets, reset values, field positions and timing constants of the charge configuration bank
package charge_cfg_pkg;
   // Clock
   localparam int CLK_PERIOD_PS = 8000;
   // Register indices on the register port
   localparam logic [3:0] ADDR_MODE_OUT = 4'h0;
   localparam logic [3:0] ADDR_CHARGE_ON = 4'h1;
   localparam logic [3:0] ADDR_RAMP_CUR = 4'h2;
   localparam logic [3:0] ADDR_CV_FIN = 4'h3;
   localparam logic [3:0] ADDR_TIMERS = 4'h4;
   localparam logic [3:0] ADDR_HOT_PEND = 4'h5;
   localparam logic [3:0] ADDR_WARM = 4'h6;
   localparam logic [3:0] ADDR_COOL = 4'h7;
   localparam logic [3:0] ADDR_HYST = 4'ha;
   // Reset values
   localparam logic [7:0] RST_RAMP_CUR = 8'h54;
   localparam logic [7:0] RST_CV_FIN = 8'h10;
   localparam logic [7:0] RST_TIMERS = 8'h0f;
   localparam logic [7:0] RST_HOT_PEND = 8'h99;
   localparam logic [7:0] RST_WARM = 8'hb1;
   localparam logic [7:0] RST_COOL = 8'h56;
   localparam logic [4:0] RST_HYST = 5'h12;
   // Field positions
   localparam int POS_RAMP = 0;
   localparam int POS_ZONE_CUR = 2;
   localparam int POS_FIN = 0;
   localparam int POS_ZONE_CV = 2;
   localparam int POS_TRICKLE = 0;
   localparam int POS_FAST = 2;
   localparam int POS_HALT = 4;
   localparam int POS_FULL = 6;
   localparam int POS_START = 7;
   localparam int POS_APPLY = 7;
   localparam logic [7:0] TIMERS_WR_MASK = 8'hdf;
   // Thresholds: 0 hot pending, 1 warm entry, 2 cool entry
   localparam logic [2:0] THR_LEAD = 3'b100;
   localparam logic [2:0] THR_RET_UP = 3'b011;
   // Ramp step times in picoseconds and derived cycle counts
   localparam longint RAMP_T0_PS = 64'd15625000000;
   localparam longint RAMP_T1_PS = 64'd7812500000;
   localparam longint RAMP_T2_PS = 64'd3125000000;
   localparam int RAMP_C0 = int'(RAMP_T0_PS / CLK_PERIOD_PS);
   localparam int RAMP_C1 = int'(RAMP_T1_PS / CLK_PERIOD_PS);
   localparam int RAMP_C2 = int'(RAMP_T2_PS / CLK_PERIOD_PS);
   // Decoded values
   localparam logic [2:0] CUR_FULL = 3'h4;
   localparam logic [2:0] CUR_HALF = 3'h2;
   localparam logic [2:0] CUR_QUARTER = 3'h1;
   localparam logic [12:0] CV_4050 = 13'hfd2;
   localparam logic [12:0] CV_4200 = 13'h1068;
   localparam logic [12:0] CV_4350 = 13'h10fe;
   localparam logic [2:0] FIN_X010 = 3'h2;
   localparam logic [2:0] FIN_X005 = 3'h1;
   localparam logic [2:0] FIN_X015 = 3'h3;
   localparam logic [2:0] FIN_X020 = 3'h4;
   localparam logic [8:0] MIN_60 = 9'h3c;
   localparam logic [8:0] MIN_120 = 9'h78;
   localparam logic [8:0] MIN_180 = 9'hb4;
   localparam logic [8:0] MIN_240 = 9'hf0;
   localparam logic [8:0] MIN_300 = 9'h12c;
   localparam logic [8:0] MIN_360 = 9'h168;
   localparam logic [10:0] START_1500 = 11'h5dc;
   localparam logic [10:0] START_0 = 11'h000;
endpackage

// ==== zone_setting_decode.sv ====
// Decode of one temperature zone's current and voltage codes
`timescale 1ns/1ps
`default_nettype none
module zone_setting_decode
   import charge_cfg_pkg::*;
(
   // Codes
   input wire logic [1:0] cur_code,
   input wire logic [1:0] cv_code,
   // Decoded values
   output logic [2:0] cur_quarters,
   output logic [12:0] cv_mv
);
   always_comb
   begin
      unique case (cur_code)
         2'h0: cur_quarters = CUR_FULL;
         2'h1: cur_quarters = CUR_HALF;
         default: cur_quarters = CUR_QUARTER;
      endcase
      unique case (cv_code)
         2'h1: cv_mv = CV_4200;
         2'h2: cv_mv = CV_4350;
         default: cv_mv = CV_4050;
      endcase
   end
endmodule
`default_nettype wire

// ==== threshold_levels.sv ====
// Entry and return compare levels of one thermistor threshold
`timescale 1ns/1ps
`default_nettype none
module threshold_levels #(
   parameter bit LEAD = 1'b0,
   parameter bit RET_UP = 1'b1
) (
   // Applied settings
   input wire logic [7:0] base,
   input wire logic [4:0] hyst,
   // Levels
   output logic [11:0] entry_level,
   output logic [11:0] return_level
);
   logic [11:0] hyst_ext;
   always_comb
   begin
      entry_level = {LEAD, base, 3'b000};
      hyst_ext = {4'h0, hyst, 3'b000};
      if (RET_UP)
         return_level = entry_level + hyst_ext;
      else
         return_level = entry_level - hyst_ext;
   end
endmodule
`default_nettype wire

// ==== charge_config_register_bank.sv ====
// Charge configuration register bank with thermistor zone tracking
`timescale 1ns/1ps
`default_nettype none
module charge_config_register_bank
   import charge_cfg_pkg::*;
#(
   parameter int RAMP_CYC0 = RAMP_C0,
   parameter int RAMP_CYC1 = RAMP_C1,
   parameter int RAMP_CYC2 = RAMP_C2
) (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic ce,
   // Register port
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic wr_from_serial,
   input wire logic write_unlock,
   output logic [7:0] reg_rdata,
   // Charge controller interface
   input wire logic charge_mode,
   input wire logic [11:0] thermistor_input,
   input wire logic thermistor_valid,
   output logic charge_start_enable,
   output logic charge_flow_reset,
   output logic [20:0] ramp_step_time,
   output logic [2:0] cool_zone_current,
   output logic [2:0] normal_zone_current,
   output logic [2:0] warm_zone_current,
   output logic [2:0] completion_current_select,
   output logic [12:0] cool_zone_cv_target,
   output logic [12:0] normal_zone_cv_target,
   output logic [12:0] warm_zone_cv_target,
   output logic [8:0] trickle_time_limit,
   output logic [8:0] fast_time_limit,
   output logic timer_halt,
   output logic continue_after_full,
   output logic [10:0] start_threshold_select,
   output logic hot_pending_zone,
   output logic warm_zone,
   output logic cool_zone,
   // Mode pin, open drain
   output logic mode_pin_o,
   output logic mode_pin_oe
);
   // Step counter output is 21 bits wide; zero would never step
   if (RAMP_CYC0 < 1 || RAMP_CYC1 < 1 || RAMP_CYC2 < 1 ||
       RAMP_CYC0 >= (1 << 21) || RAMP_CYC1 >= (1 << 21) ||
       RAMP_CYC2 >= (1 << 21))
   begin : g_bad_ramp
      $error("ramp step counts must lie in 1 .. 2**21-1");
   end

   typedef struct packed {
      logic mode_off;
      logic charge_on;
      logic [7:0] ramp_cur;
      logic [7:0] cv_fin;
      logic [7:0] timers;
      logic [2:0][7:0] thr;
      logic [4:0] hyst;
      logic apply;
      logic [2:0][7:0] act_thr;
      logic [4:0] act_hyst;
      logic [2:0] zone;
      logic [7:0] rdata;
      logic flow_rst;
      logic mode_oe;
      logic [20:0] ramp_cyc;
      logic [2:0][2:0] cur;
      logic [2:0][12:0] cv;
      logic [2:0] fin;
      logic [8:0] trk;
      logic [8:0] fst;
      logic halt;
      logic full;
      logic [10:0] start_mv;
   } bank_state_t;

   bank_state_t st_q;
   bank_state_t st_d;
   logic wr_ok;
   wire logic [2:0][11:0] entry_lvl;
   wire logic [2:0][11:0] return_lvl;
   wire logic [2:0][2:0] dec_cur;
   wire logic [2:0][12:0] dec_cv;

   // Serial host writes are dropped until the unlock bit is set
   assign wr_ok = reg_wr_en && (!wr_from_serial || write_unlock);

   // Zone index 0 cool, 1 normal, 2 warm: fields sit low to high in order
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_zone
         zone_setting_decode u_dec (
            .cur_code(st_q.ramp_cur[POS_ZONE_CUR + 2*gi +: 2]),
            .cv_code(st_q.cv_fin[POS_ZONE_CV + 2*gi +: 2]),
            .cur_quarters(dec_cur[gi]),
            .cv_mv(dec_cv[gi])
         );
         threshold_levels #(
            .LEAD(THR_LEAD[gi]),
            .RET_UP(THR_RET_UP[gi])
         ) u_thr (
            .base(st_q.act_thr[gi]),
            .hyst(st_q.act_hyst),
            .entry_level(entry_lvl[gi]),
            .return_level(return_lvl[gi])
         );
      end
   endgenerate

   always_comb
   begin
      st_d = st_q;
      st_d.flow_rst = 1'b0;
      if (wr_ok)
      begin
         unique case (reg_addr)
            ADDR_MODE_OUT: st_d.mode_off = reg_wdata[0];
            ADDR_CHARGE_ON:
            begin
               st_d.charge_on = reg_wdata[0];
               st_d.flow_rst = !reg_wdata[0];
            end
            ADDR_RAMP_CUR: st_d.ramp_cur = reg_wdata;
            ADDR_CV_FIN: st_d.cv_fin = reg_wdata;
            ADDR_TIMERS: st_d.timers = reg_wdata & TIMERS_WR_MASK;
            ADDR_HOT_PEND: st_d.thr[0] = reg_wdata;
            ADDR_WARM: st_d.thr[1] = reg_wdata;
            ADDR_COOL: st_d.thr[2] = reg_wdata;
            ADDR_HYST: st_d.hyst = reg_wdata[4:0];
            default: ;
         endcase
      end
      // Apply takes shadow values, then clears itself; a new request wins
      if (st_q.apply)
      begin
         st_d.act_thr = st_q.thr;
         st_d.act_hyst = st_q.hyst;
         st_d.apply = 1'b0;
      end
      if (wr_ok && reg_addr == ADDR_HYST && reg_wdata[POS_APPLY])
         st_d.apply = 1'b1;
      // Hot side: a hotter thermistor reads lower; cool side reads higher
      if (thermistor_valid)
      begin
         for (int i = 0; i < 3; i++)
         begin
            if (THR_RET_UP[i])
            begin
               if (thermistor_input < entry_lvl[i])
                  st_d.zone[i] = 1'b1;
               else if (thermistor_input > return_lvl[i])
                  st_d.zone[i] = 1'b0;
            end
            else
            begin
               if (thermistor_input > entry_lvl[i])
                  st_d.zone[i] = 1'b1;
               else if (thermistor_input < return_lvl[i])
                  st_d.zone[i] = 1'b0;
            end
         end
      end
      if (reg_rd_en)
      begin
         unique case (reg_addr)
            ADDR_MODE_OUT: st_d.rdata = {7'h00, st_q.mode_off};
            ADDR_CHARGE_ON: st_d.rdata = {7'h00, st_q.charge_on};
            ADDR_RAMP_CUR: st_d.rdata = st_q.ramp_cur;
            ADDR_CV_FIN: st_d.rdata = st_q.cv_fin;
            ADDR_TIMERS: st_d.rdata = st_q.timers;
            ADDR_HOT_PEND: st_d.rdata = st_q.thr[0];
            ADDR_WARM: st_d.rdata = st_q.thr[1];
            ADDR_COOL: st_d.rdata = st_q.thr[2];
            ADDR_HYST: st_d.rdata = {st_q.apply, 2'b00, st_q.hyst};
            default: st_d.rdata = 8'h00;
         endcase
      end
      st_d.mode_oe = charge_mode && !st_q.mode_off;
      unique case (st_q.ramp_cur[POS_RAMP +: 2])
         2'h1: st_d.ramp_cyc = 21'(RAMP_CYC1);
         2'h2: st_d.ramp_cyc = 21'(RAMP_CYC2);
         default: st_d.ramp_cyc = 21'(RAMP_CYC0);
      endcase
      st_d.cur = dec_cur;
      st_d.cv = dec_cv;
      unique case (st_q.cv_fin[POS_FIN +: 2])
         2'h0: st_d.fin = FIN_X010;
         2'h1: st_d.fin = FIN_X005;
         2'h2: st_d.fin = FIN_X015;
         default: st_d.fin = FIN_X020;
      endcase
      unique case (st_q.timers[POS_TRICKLE +: 2])
         2'h0: st_d.trk = MIN_60;
         2'h1: st_d.trk = MIN_120;
         default: st_d.trk = MIN_180;
      endcase
      unique case (st_q.timers[POS_FAST +: 2])
         2'h0: st_d.fst = MIN_180;
         2'h1: st_d.fst = MIN_240;
         2'h2: st_d.fst = MIN_300;
         default: st_d.fst = MIN_360;
      endcase
      st_d.halt = st_q.timers[POS_HALT];
      st_d.full = st_q.timers[POS_FULL];
      st_d.start_mv = st_q.timers[POS_START] ? START_0 : START_1500;
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         st_q <= '0;
         st_q.ramp_cur <= RST_RAMP_CUR;
         st_q.cv_fin <= RST_CV_FIN;
         st_q.timers <= RST_TIMERS;
         st_q.thr <= {RST_COOL, RST_WARM, RST_HOT_PEND};
         st_q.act_thr <= {RST_COOL, RST_WARM, RST_HOT_PEND};
         st_q.hyst <= RST_HYST;
         st_q.act_hyst <= RST_HYST;
         st_q.ramp_cyc <= 21'(RAMP_CYC0);
         st_q.cur <= {CUR_HALF, CUR_HALF, CUR_HALF};
         st_q.cv <= {CV_4050, CV_4200, CV_4050};
         st_q.fin <= FIN_X010;
         st_q.trk <= MIN_180;
         st_q.fst <= MIN_360;
         st_q.start_mv <= START_1500;
      end
      else if (ce)
         st_q <= st_d;
   end

   assign reg_rdata = st_q.rdata;
   assign charge_start_enable = st_q.charge_on;
   assign charge_flow_reset = st_q.flow_rst;
   assign ramp_step_time = st_q.ramp_cyc;
   assign cool_zone_current = st_q.cur[0];
   assign normal_zone_current = st_q.cur[1];
   assign warm_zone_current = st_q.cur[2];
   assign completion_current_select = st_q.fin;
   assign cool_zone_cv_target = st_q.cv[0];
   assign normal_zone_cv_target = st_q.cv[1];
   assign warm_zone_cv_target = st_q.cv[2];
   assign trickle_time_limit = st_q.trk;
   assign fast_time_limit = st_q.fst;
   assign timer_halt = st_q.halt;
   assign continue_after_full = st_q.full;
   assign start_threshold_select = st_q.start_mv;
   assign hot_pending_zone = st_q.zone[0];
   assign warm_zone = st_q.zone[1];
   assign cool_zone = st_q.zone[2];
   // Pin only ever pulls low; release is the high level
   assign mode_pin_o = 1'b0;
   assign mode_pin_oe = st_q.mode_oe;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   a_mode_pin_off: assert property (
      ce && st_q.mode_off |=> !mode_pin_oe)
      else $error("mode pin pulled while disabled");
   a_stop_resets_flow: assert property (
      ce && wr_ok && reg_addr == ADDR_CHARGE_ON && !reg_wdata[0]
      |=> charge_flow_reset && !charge_start_enable)
      else $error("charge stop did not reset flow");
   a_ramp_fast_code: assert property (
      ce && st_q.ramp_cur[1:0] == 2'h2 |=> ramp_step_time == RAMP_CYC2)
      else $error("ramp code 2 wrong step time");
   a_fin_code_map: assert property (
      ce && st_q.cv_fin[1:0] == 2'h1 |=> completion_current_select == FIN_X005)
      else $error("completion code 1 wrong");
   a_fast_limit_map: assert property (
      ce && st_q.timers[3:2] == 2'h3 |=> fast_time_limit == MIN_360)
      else $error("fast limit code 3 wrong");
   a_halt_follows: assert property (
      ce |=> timer_halt == $past(st_q.timers[POS_HALT]))
      else $error("timer halt not following bit");
   a_apply_self_clear: assert property (
      ce && st_q.apply && !(wr_ok && reg_addr == ADDR_HYST && reg_wdata[7])
      |=> !st_q.apply && st_q.act_thr == $past(st_q.thr))
      else $error("apply bit not cleared or values not taken");
   a_no_early_apply: assert property (
      ce && !st_q.apply |=> $stable(st_q.act_thr) && $stable(st_q.act_hyst))
      else $error("thresholds changed without apply");
   a_locked_serial: assert property (
      ce && reg_wr_en && wr_from_serial && !write_unlock && !st_q.apply
      |=> $stable(st_q.thr) && $stable(st_q.ramp_cur) &&
         $stable(st_q.charge_on))
      else $error("locked serial write changed bank");
   a_reserved_zero: assert property (
      ce && reg_rd_en && reg_addr == ADDR_TIMERS |=> reg_rdata[5] == 1'b0)
      else $error("reserved bit reads nonzero");
   a_cool_entry: assert property (
      ce && thermistor_valid && thermistor_input > {1'b1, st_q.act_thr[2], 3'b000}
      |=> cool_zone)
      else $error("cool zone not entered");
endmodule
`default_nettype wire

// ==== cfg_writer_model.sv ====
// Host or transmitter model that reads and writes the configuration bank
`timescale 1ns/1ps
`default_nettype none
module cfg_writer_model (
   // Clock
   input wire logic mclk,
   // Register port towards the bank
   output logic reg_wr_en,
   output logic reg_rd_en,
   output logic [3:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic wr_from_serial,
   output logic write_unlock,
   input wire logic [7:0] reg_rdata
);
   initial
   begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 4'hf;
      reg_wdata = 8'h00;
      wr_from_serial = 1'b0;
      write_unlock = 1'b0;
   end

   // Unlock level settles a cycle ahead of the request it qualifies
   task automatic wr(input logic [3:0] a, input logic [7:0] d,
                     input logic ser, input logic unl);
      @(negedge mclk);
      write_unlock = unl;
      @(negedge mclk);
      reg_wr_en = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      wr_from_serial = ser;
      @(negedge mclk);
      reg_wr_en = 1'b0;
      // Released lines show garbage, not the last value
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(negedge mclk);
      reg_rd_en = 1'b1;
      reg_addr = a;
      @(negedge mclk);
      reg_rd_en = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask
endmodule
`default_nettype wire

// ==== charge_config_register_bank_tb.sv ====
// Self-checking testbench of the charge configuration bank
`timescale 1ns/1ps
`default_nettype none
module charge_config_register_bank_tb;
   import charge_cfg_pkg::*;
   logic mclk = 1'b0, rst_b = 1'b0, ce = 1'b1, charge_mode = 1'b0;
   logic thermistor_valid = 1'b0;
   logic [11:0] thermistor_input = 12'h000;
   logic reg_wr_en, reg_rd_en, wr_from_serial, write_unlock;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic charge_start_enable, charge_flow_reset, timer_halt;
   logic continue_after_full, hot_pending_zone, warm_zone, cool_zone;
   logic mode_pin_o, mode_pin_oe;
   logic [20:0] ramp_step_time;
   logic [2:0] cool_zone_current, normal_zone_current, warm_zone_current;
   logic [2:0] completion_current_select;
   logic [12:0] cool_zone_cv_target, normal_zone_cv_target;
   logic [12:0] warm_zone_cv_target;
   logic [8:0] trickle_time_limit, fast_time_limit;
   logic [10:0] start_threshold_select;
   int error_cnt = 0, n_tests = 0, i;
   logic [7:0] d2, d3, d4;
   logic [11:0] x;
   logic eh, ew, ec;
   logic [7:0] rst_tab [0:11] = '{8'h00, 8'h00, 8'h54, 8'h10, 8'h0f,
      8'h99, 8'hb1, 8'h56, 8'h00, 8'h00, 8'h12, 8'h00};
   logic [11:0] corner [0:11] = '{12'h120, 12'h121, 12'h0ff, 12'h100,
      12'h1a0, 12'h1a1, 12'h17f, 12'ha00, 12'ha01, 12'h9e0, 12'h9df,
      12'h200};

   always #4 mclk = ~mclk;

   cfg_writer_model u_host (.mclk(mclk), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .wr_from_serial(wr_from_serial), .write_unlock(write_unlock),
      .reg_rdata(reg_rdata));

   // Short ramp counts keep the run small
   charge_config_register_bank #(.RAMP_CYC0(4), .RAMP_CYC1(2),
      .RAMP_CYC2(1)) u_dut (.mclk(mclk), .rst_b(rst_b), .ce(ce),
      .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .wr_from_serial(wr_from_serial),
      .write_unlock(write_unlock), .reg_rdata(reg_rdata),
      .charge_mode(charge_mode), .thermistor_input(thermistor_input),
      .thermistor_valid(thermistor_valid),
      .charge_start_enable(charge_start_enable),
      .charge_flow_reset(charge_flow_reset),
      .ramp_step_time(ramp_step_time),
      .cool_zone_current(cool_zone_current),
      .normal_zone_current(normal_zone_current),
      .warm_zone_current(warm_zone_current),
      .completion_current_select(completion_current_select),
      .cool_zone_cv_target(cool_zone_cv_target),
      .normal_zone_cv_target(normal_zone_cv_target),
      .warm_zone_cv_target(warm_zone_cv_target),
      .trickle_time_limit(trickle_time_limit),
      .fast_time_limit(fast_time_limit), .timer_halt(timer_halt),
      .continue_after_full(continue_after_full),
      .start_threshold_select(start_threshold_select),
      .hot_pending_zone(hot_pending_zone), .warm_zone(warm_zone),
      .cool_zone(cool_zone), .mode_pin_o(mode_pin_o),
      .mode_pin_oe(mode_pin_oe));

   function automatic logic [20:0] cur_f(input logic [1:0] c);
      return (c == 2'd0) ? 21'd4 : (c == 2'd1) ? 21'd2 : 21'd1;
   endfunction
   function automatic logic [20:0] cv_f(input logic [1:0] c);
      return (c == 2'd1) ? 21'd4200 : (c == 2'd2) ? 21'd4350 : 21'd4050;
   endfunction
   function automatic logic [20:0] fin_f(input logic [1:0] c);
      return (c == 2'd0) ? 21'd2 : (c == 2'd1) ? 21'd1 : {19'd0, c} + 21'd1;
   endfunction
   // Hotter reads lower; high-side flags set below entry, low-side above
   function automatic logic zf(input logic f, input logic [11:0] v,
                               input logic [11:0] e, input logic [11:0] r,
                               input logic hi);
      if (hi)
      begin
         return (v < e) ? 1'b1 : (v > r) ? 1'b0 : f;
      end
      return (v > e) ? 1'b1 : (v < r) ? 1'b0 : f;
   endfunction

   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED t=%0t read %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_out(input logic [20:0] got, input logic [20:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED t=%0t output %0d expected %0d", $time, got,
                  exp);
      end
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
      logic [7:0] d;
      u_host.rd(a, d);
      chk_reg(d, exp);
   endtask
   task automatic chk_dec(input logic [7:0] r2, input logic [7:0] r3,
                          input logic [7:0] r4);
      chk_out(ramp_step_time, (r2[1:0] == 2'd1) ? 21'd2 :
              (r2[1:0] == 2'd2) ? 21'd1 : 21'd4);
      chk_out(cool_zone_current, cur_f(r2[3:2]));
      chk_out(normal_zone_current, cur_f(r2[5:4]));
      chk_out(warm_zone_current, cur_f(r2[7:6]));
      chk_out(completion_current_select, fin_f(r3[1:0]));
      chk_out(cool_zone_cv_target, cv_f(r3[3:2]));
      chk_out(normal_zone_cv_target, cv_f(r3[5:4]));
      chk_out(warm_zone_cv_target, cv_f(r3[7:6]));
      chk_out(trickle_time_limit, (r4[1:0] == 2'd0) ? 21'd60 :
              (r4[1:0] == 2'd1) ? 21'd120 : 21'd180);
      chk_out(fast_time_limit, 21'd180 + 21'd60 * r4[3:2]);
      chk_out(timer_halt, r4[4]);
      chk_out(continue_after_full, r4[6]);
      chk_out(start_threshold_select, r4[7] ? 21'd0 : 21'd1500);
   endtask
   task automatic therm(input logic [11:0] v);
      @(negedge mclk);
      thermistor_input = v;
      thermistor_valid = 1'b1;
      @(negedge mclk);
      thermistor_valid = 1'b0;
      thermistor_input = ~v;
      @(negedge mclk);
   endtask

   task automatic end_of_test;
      $display("errors %0d of %0d checks", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial
   begin
      repeat (100000) @(posedge mclk);
      error_cnt++;
      $display("CHECK FAILED t=%0t run did not finish", $time);
      end_of_test();
   end

   initial
   begin
      void'($urandom(32'h6ae2));
      repeat (16) @(negedge mclk);
      rst_b = 1'b1;
      for (i = 0; i < 12; i++)
         rd_chk(i[3:0], rst_tab[i]);
      chk_dec(8'h54, 8'h10, 8'h0f);
      for (i = 0; i < 14; i++)
      begin
         d2 = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
         d3 = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
         d4 = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
         u_host.wr(ADDR_RAMP_CUR, d2, i[0], 1'b1);
         u_host.wr(ADDR_CV_FIN, d3, i[1], 1'b1);
         u_host.wr(ADDR_TIMERS, d4, i[2], 1'b1);
         repeat (2) @(negedge mclk);
         chk_dec(d2, d3, d4 & TIMERS_WR_MASK);
         rd_chk(ADDR_TIMERS, d4 & TIMERS_WR_MASK);
      end
      // Locked serial write and a write with the clock disabled
      u_host.wr(ADDR_RAMP_CUR, ~d2, 1'b1, 1'b0);
      rd_chk(ADDR_RAMP_CUR, d2);
      ce = 1'b0;
      u_host.wr(ADDR_CHARGE_ON, 8'h01, 1'b0, 1'b0);
      ce = 1'b1;
      rd_chk(ADDR_CHARGE_ON, 8'h00);
      charge_mode = 1'b1;
      u_host.wr(ADDR_MODE_OUT, 8'hff, 1'b0, 1'b0);
      rd_chk(ADDR_MODE_OUT, 8'h01);
      chk_out(mode_pin_oe, 21'd0);
      u_host.wr(ADDR_MODE_OUT, 8'h00, 1'b0, 1'b0);
      repeat (2) @(negedge mclk);
      chk_out(mode_pin_oe, 21'd1);
      chk_out(mode_pin_o, 21'd0);
      charge_mode = 1'b0;
      repeat (2) @(negedge mclk);
      chk_out(mode_pin_oe, 21'd0);
      u_host.wr(ADDR_CHARGE_ON, 8'h01, 1'b1, 1'b1);
      @(negedge mclk);
      chk_out(charge_start_enable, 21'd1);
      u_host.wr(ADDR_CHARGE_ON, 8'h00, 1'b0, 1'b0);
      chk_out({charge_start_enable, charge_flow_reset}, 21'd1);
      @(negedge mclk);
      chk_out(charge_flow_reset, 21'd0);
      // New levels wait in shadow until applied
      u_host.wr(ADDR_HOT_PEND, 8'h20, 1'b0, 1'b0);
      u_host.wr(ADDR_WARM, 8'h30, 1'b0, 1'b0);
      u_host.wr(ADDR_COOL, 8'h40, 1'b0, 1'b0);
      u_host.wr(ADDR_HYST, 8'h04, 1'b0, 1'b0);
      therm(12'h200);
      chk_out({hot_pending_zone, warm_zone, cool_zone}, 21'd6);
      eh = 1'b1;
      ew = 1'b1;
      ec = 1'b0;
      u_host.wr(ADDR_HYST, 8'h84, 1'b0, 1'b0);
      rd_chk(ADDR_HYST, 8'h04);
      for (i = 0; i < 40; i++)
      begin
         x = (i < 12) ? corner[i] : 12'($urandom);
         therm(x);
         eh = zf(eh, x, 12'h100, 12'h120, 1'b1);
         ew = zf(ew, x, 12'h180, 12'h1a0, 1'b1);
         ec = zf(ec, x, 12'ha00, 12'h9e0, 1'b0);
         chk_out(hot_pending_zone, eh);
         chk_out(warm_zone, ew);
         chk_out(cool_zone, ec);
      end
      end_of_test();
   end
endmodule
`default_nettype wire
